/* design/switch_pkg.sv */
// constants for the eight-channel serial switch control block
package switch_pkg;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned FRAME_STEP = 8;
  localparam int unsigned OUT_LSB = 0;
  localparam int unsigned DETECT_LSB = 8;
  localparam int unsigned STATUS_ZERO_LSB = 8;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] STEP_MASK = 8'h07;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] SYNC_RESET = 2'b00;
  localparam logic [1:0] SELECT_SYNC_RESET = 2'b11;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned LINK_PERIOD_NS = 200;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_APPLY = 3'b100
  } frame_state_t;
endpackage

/* design/pin_sync.sv */
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync width must be at least one");
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= INIT;
      pin_out <= INIT;
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule

/* design/fault_latch.sv */
// per-channel fault flag evaluation and latching
`timescale 1ns/1ps
module fault_latch #(
  parameter int unsigned CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // channel state
  input wire logic [CHANNELS-1:0] drive_on,
  input wire logic [CHANNELS-1:0] detect_on,
  input wire logic [CHANNELS-1:0] over_temp,
  input wire logic [CHANNELS-1:0] short_fault,
  input wire logic [CHANNELS-1:0] open_load,
  // frame capture
  input wire logic capture,
  output logic [CHANNELS-1:0] flags_q
);
  initial begin
    if (CHANNELS < 1) begin
      $error("fault_latch needs at least one channel");
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic fault_now;
    // off-state open load only with detect current; on-state open ignored
    assign fault_now = over_temp[ch] | short_fault[ch]
        | (open_load[ch] & ~drive_on[ch] & detect_on[ch]);

    // set wins over the clear at frame capture
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        flags_q[ch] <= 1'b0;
      end else if (fault_now) begin
        flags_q[ch] <= 1'b1;
      end else if (capture) begin
        flags_q[ch] <= 1'b0;
      end
    end
  end
endmodule

/* design/switch_serial_ctrl.sv */
// serial command and fault reporting logic of an eight-channel switch
//
// Overview of operation
// - 16-bit command in, 16-bit status out, MSB first both ways.
// - command acts only on chip select rising edge.
// - command bits 0..7 switch outputs one to eight on when 1.
// - command bits 8..15 enable open-load detect current when 1.
// - status bits 15..8 always zero.
// - status bits 0..7 flag a fault per output.
// - status reflects faults of previously applied state.
// - status shifts out while command shifts in, one bit per clock.
// - overtemperature sets that output's flag.
// - short to supply or overcurrent sets that output's flag.
// - off-state open load flagged only with detect current on.
// - overvoltage forces all outputs off, restores commanded state.
// - overtemperature turns off only that output until recovery.
// - sleep or supply loss resets outputs and detect currents.
// - 32-bit frame returns zeros, flags, then echoed first word.
// - longer frames apply the last 16 bits shifted in.
// - only 16 plus multiples of 8 clocks are accepted.
// - sample input on falling clock, change output on rising.
// - deselected: ignore clock and input, serial output released.
// - outputs five and six OR command bit with direct pwm pins.
// - enable low holds outputs off and detect currents off.
`timescale 1ns/1ps
module switch_serial_ctrl
  import switch_pkg::*;
#(
  parameter int unsigned CHANNELS_P = CHANNELS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link pins
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // device control pins
  input wire logic enable,
  input wire logic direct_pwm_input_five,
  input wire logic direct_pwm_input_six,
  // protection indications
  input wire logic battery_supply_overvoltage,
  input wire logic [7:0] thermal_limit,
  input wire logic [7:0] short_fault,
  input wire logic [7:0] open_load,
  // output stage controls
  output logic [7:0] drive_on,
  output logic [7:0] detect_current_on
);
  frame_state_t state_q;
  logic [0:0] cs_n_sync;
  logic [0:0] sclk_sync;
  logic [0:0] sin_sync;
  logic [0:0] en_sync;
  logic [1:0] pwm_sync;
  logic ov_sync;
  logic [7:0] thermal_limit_sync;
  logic [7:0] short_sync;
  logic [7:0] open_sync;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [15:0] shift_q;
  logic [15:0] command_q;
  logic [7:0] pulse_cnt_q;
  logic [7:0] flags;
  logic capture;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_ok;
  logic [7:0] cmd_out;
  logic [7:0] cmd_det;
  logic [7:0] drive_d;

  initial begin
    if (CHANNELS_P != CHANNELS) begin
      $error("switch_serial_ctrl serves exactly eight channels");
    end
  end

  // link, control and protection pin synchronisers
  pin_sync #(.WIDTH(1), .INIT(SELECT_SYNC_RESET[0])) u_sync_cs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(chip_select_n),
    .pin_out(cs_n_sync)
  );

  pin_sync #(.WIDTH(1)) u_sync_sclk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(serial_clk),
    .pin_out(sclk_sync)
  );

  pin_sync #(.WIDTH(1)) u_sync_sin (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(serial_in),
    .pin_out(sin_sync)
  );

  pin_sync #(.WIDTH(1)) u_sync_en (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(enable),
    .pin_out(en_sync)
  );

  pin_sync #(.WIDTH(2)) u_sync_pwm (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({direct_pwm_input_six, direct_pwm_input_five}),
    .pin_out(pwm_sync)
  );

  pin_sync #(.WIDTH(25)) u_sync_prot (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({battery_supply_overvoltage, thermal_limit, short_fault,
             open_load}),
    .pin_out({ov_sync, thermal_limit_sync, short_sync, open_sync})
  );

  // fault flags, cleared when loaded into a frame
  fault_latch #(.CHANNELS(CHANNELS)) u_faults (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .drive_on(drive_on),
    .detect_on(detect_current_on),
    .over_temp(thermal_limit_sync),
    .short_fault(short_sync),
    .open_load(open_sync),
    .capture(capture),
    .flags_q(flags)
  );

  // edge detection on synchronised link pins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_sync[0];
      cs_prev_q <= cs_n_sync[0];
    end
  end

  assign sclk_rise = sclk_sync[0] & ~sclk_prev_q;
  assign sclk_fall = ~sclk_sync[0] & sclk_prev_q;
  assign cs_fall = ~cs_n_sync[0] & cs_prev_q;
  assign cs_rise = cs_n_sync[0] & ~cs_prev_q;
  assign capture = cs_fall & en_sync[0];
  assign frame_ok = (pulse_cnt_q >= 8'(WORD_BITS))
      && ((pulse_cnt_q & STEP_MASK) == 8'h00);

  // frame sequencing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else if (!en_sync[0]) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_rise) begin
            state_q <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // clock pulse counter, wrapping one step past a full word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt_q <= 8'h00;
    end else if (cs_fall) begin
      pulse_cnt_q <= 8'h00;
    end else if (state_q == ST_SHIFT && sclk_fall) begin
      if (pulse_cnt_q == 8'(WORD_BITS + FRAME_STEP - 1)) begin
        pulse_cnt_q <= 8'(WORD_BITS);
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 8'h01;
      end
    end
  end

  // single shift register: status loaded, command shifted in behind it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_q <= STATUS_RESET;
    end else if (capture) begin
      shift_q <= {8'h00, flags};
    end else if (state_q == ST_SHIFT && !cs_n_sync[0] && sclk_fall) begin
      shift_q <= {shift_q[14:0], sin_sync[0]};
    end
  end

  // serial output changes on rising clock, released when deselected
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (cs_n_sync[0] || !en_sync[0]) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (capture) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b1;
    end else if (state_q == ST_SHIFT && sclk_rise) begin
      serial_out <= shift_q[15];
      serial_out_oe <= 1'b1;
    end
  end

  // command latch, applied only for accepted frames
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      command_q <= COMMAND_RESET;
    end else if (!en_sync[0]) begin
      command_q <= COMMAND_RESET;
    end else if (state_q == ST_APPLY && frame_ok) begin
      command_q <= shift_q;
    end
  end

  assign cmd_out = command_q[OUT_LSB +: CHANNELS];
  assign cmd_det = command_q[DETECT_LSB +: CHANNELS];

  // output drive with pwm, overvoltage and thermal shutdown
  always_comb begin
    drive_d = cmd_out;
    drive_d[4] = cmd_out[4] | pwm_sync[0];
    drive_d[5] = cmd_out[5] | pwm_sync[1];
    drive_d = drive_d & ~thermal_limit_sync;
    if (ov_sync || !en_sync[0]) begin
      drive_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drive_on <= FLAGS_RESET;
      detect_current_on <= FLAGS_RESET;
    end else begin
      drive_on <= drive_d;
      detect_current_on <= en_sync[0] ? cmd_det : FLAGS_RESET;
    end
  end
endmodule

/* bench/switch_serial_ctrl_chk.sv */
// port assertions for the serial switch control block
`timescale 1ns/1ps
module switch_serial_ctrl_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // control and protection
  input wire logic enable,
  input wire logic direct_pwm_input_five,
  input wire logic direct_pwm_input_six,
  input wire logic battery_supply_overvoltage,
  input wire logic [7:0] thermal_limit,
  // output stage
  input wire logic [7:0] drive_on,
  input wire logic [7:0] detect_current_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_frame_start;
    $fell(chip_select_n) ##[1:4] $rose(serial_out_oe);
  endsequence
  property p_first_zero; s_frame_start |-> !serial_out; endproperty
  a_first_zero: assert property (p_first_zero) else $error("msb set");
  property p_oe_off; chip_select_n [*5] |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe held");
  property p_oe_on; $fell(chip_select_n) |-> ##[1:4] serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_out_hold;
    (serial_out_oe && !serial_clk) [*5] |-> $stable(serial_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
  property p_frame_hold; (!chip_select_n && $stable({enable, thermal_limit,
    battery_supply_overvoltage, direct_pwm_input_five, direct_pwm_input_six}))
    [*6] |-> $stable(drive_on); endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("early");
  property p_sleep;
    !enable [*6] |-> drive_on == 8'h00 && detect_current_on == 8'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep drive");
  property p_ovolt; battery_supply_overvoltage [*5] |-> drive_on == 8'h00;
  endproperty
  a_ovolt: assert property (p_ovolt) else $error("ov drive");
  property p_otemp;
    $stable(thermal_limit) [*5] |-> (drive_on & thermal_limit) == 8'h00;
  endproperty
  a_otemp: assert property (p_otemp) else $error("hot drive");
  property p_pwm; (direct_pwm_input_five && enable && !thermal_limit[4] &&
    !battery_supply_overvoltage) [*5] |-> drive_on[4]; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm lost");
endmodule
bind switch_serial_ctrl switch_serial_ctrl_chk i_chk (.clk_sys, .rstn,
  .chip_select_n, .serial_clk, .serial_out, .serial_out_oe, .enable,
  .direct_pwm_input_five, .direct_pwm_input_six, .battery_supply_overvoltage,
  .thermal_limit, .drive_on, .detect_current_on);

/* bench/spi_host_model.sv */
// host controller model driving the serial link
`timescale 1ns/1ps
module spi_host_model #(
  parameter int GAP_NS = 300100,
  parameter int SETTLE_NS = 2000
) (
  // link pins
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out
);
  time last_end = 0;
  logic sent_once = 1'b0;
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // select falls with clock low, msb first both ways
  task automatic xfer(input int n, input logic [31:0] tx,
    output logic [31:0] rx);
    rx = 32'h0;
    if (sent_once && (($time - last_end) < GAP_NS)) begin
      #(GAP_NS - ($time - last_end));
    end
    chip_select_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      serial_clk = 1'b1;
      #100;
      serial_clk = 1'b0;
      #50;
      rx = {rx[30:0], serial_out};
      #50;
    end
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    last_end = $time;
    sent_once = 1'b1;
    #SETTLE_NS;
  endtask
endmodule

/* bench/switch_serial_ctrl_tb_top.sv */
// self-checking bench for the serial switch control block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module switch_serial_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
  logic enable = 1'b1, battery_supply_overvoltage = 1'b0;
  logic direct_pwm_input_five = 1'b0, direct_pwm_input_six = 1'b0;
  logic [7:0] thermal_limit = 8'h00, short_fault = 8'h00, open_load = 8'h00;
  logic [7:0] drive_on, detect_current_on;
  logic [31:0] rx;
  int miscompares = 0, samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  switch_serial_ctrl i_dut (.clk_sys, .rstn, .chip_select_n, .serial_clk,
    .serial_in, .serial_out, .serial_out_oe, .enable, .direct_pwm_input_five,
    .direct_pwm_input_six, .battery_supply_overvoltage, .thermal_limit,
    .short_fault, .open_load, .drive_on, .detect_current_on);
  spi_host_model i_host (.chip_select_n, .serial_clk,
    .serial_in, .serial_out);
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic frame(input int n, input logic [31:0] tx);
    @(negedge clk_sys);
    i_host.xfer(n, tx, rx);
  endtask
  task automatic prot(input logic [2:0] s, input logic [7:0] e);
    {battery_supply_overvoltage, direct_pwm_input_five,
      direct_pwm_input_six} = s;
    repeat (8) @(negedge clk_sys);
    `CHK(drive_on, e)
  endtask
  task automatic t_integrity();
    frame(32, 32'h5AC3_0F81);
    `CHK(rx, 32'h0000_5AC3)
    `CHK(drive_on, 8'h81)
    `CHK(detect_current_on, 8'h0F)
  endtask
  task automatic t_protect();
    prot(3'b100, 8'h00);
    prot(3'b000, 8'h81);
    prot(3'b010, 8'h91);
    prot(3'b001, 8'hA1);
    prot(3'b000, 8'h81);
  endtask
  task automatic t_sleep();
    enable = 1'b0;
    repeat (8) @(negedge clk_sys);
    `CHK({drive_on, detect_current_on}, 16'h0000)
    enable = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK({drive_on, detect_current_on}, 16'h0000)
  endtask
  task automatic t_count();
    int lens[3] = '{15, 17, 23};
    foreach (lens[i]) begin
      frame(lens[i], 32'h0000_FFFF);
      `CHK({drive_on, detect_current_on}, 16'h0000)
    end
    frame(24, 32'h00FF_003C);
    `CHK(rx[23:0], 24'h0000FF)
    `CHK(drive_on, 8'h3C)
  endtask
  task automatic t_faults();
    {thermal_limit, short_fault, open_load} = 24'h0480_03;
    repeat (8) @(negedge clk_sys);
    `CHK(drive_on, 8'h38)
    frame(16, 32'h0300);
    `CHK(rx[15:0], 16'h0084)
    `CHK(detect_current_on, 8'h03)
    {thermal_limit, short_fault} = 16'h0000;
    frame(16, 32'h0300);
    `CHK(rx[15:0], 16'h0087)
    open_load = 8'h00;
    frame(16, 32'h0000);
    `CHK(rx[15:0], 16'h0003)
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_integrity();
    t_protect();
    t_sleep();
    t_count();
    t_faults();
    finish_test();
  end
endmodule
